// file: tfc_reg.sv
// Trace filter control register with mirrored trace control block fields and the trace filter.
`timescale 1ns/1ns
`include "tfc_params.svh"
// Functional notes
// [RL1] Register exists only when trace is built in; otherwise reads zero, writes ignored.
// [RL2] Read-only fields mirror the trace control block, invalid until it loads them.
// [RL3] Element filter on: trace only instructions from the selected element.
// [RL4] Context filter enable overrides element filter enable.
// [RL5] Element number is read/write, resets to zero.
// [RL6] Context filter on: trace only instructions from the selected context.
// [RL7] Context number read/write, reset zero; only low implemented bits compared.
// [RL8] Five content enables: PC, load addr, store addr, load data, store data.
// [RL9] A zero content enable suppresses that trace information.
// [RL10] Supported subset is a read-only preset code.
// [RL11] Content enables act only while tracing is on.
// [RL12] Writes leave read-only fields unchanged.
module tfc_reg
   import tfc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        reg_sel,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   input  wire logic        tcb_load,
   input  wire logic        tcb_buffers_implemented,
   input  wire logic        tcb_buffer_in_use,
   input  wire logic [2:0]  tcb_sync_period,
   output logic             mirror_valid,
   input  wire logic        trace_on,
   input  wire logic        instr_valid,
   input  wire logic [7:0]  instr_element,
   input  wire logic [7:0]  instr_context,
   output logic             instr_traced,
   output logic             emit_pc,
   output logic             emit_load_addr,
   output logic             emit_store_addr,
   output logic             emit_load_data,
   output logic             emit_store_data
);

   localparam logic IMPL = `TFC_TRACE_PRESENT;

   ////////////////////////////////////////////////////////////////////////////////////////////////////

   // Builds the full register image from its fields.
   function automatic logic [31:0] pack_image
   (
      input logic [1:0] sync_ext,
      input logic       elem_en,
      input logic [7:0] elem_num,
      input logic       ctx_en,
      input logic [7:0] ctx_num,
      input logic [4:0] mode,
      input logic [1:0] subset,
      input logic       buf_impl,
      input logic       buf_use,
      input logic [2:0] sync
   );
      logic [31:0] img;
      img = `TFC_RST_RDATA;
      img[`TFC_SYNC_EXT_LSB +: `TFC_SYNC_EXT_W] = sync_ext;
      img[`TFC_ELEM_EN_BIT]                     = elem_en;
      img[`TFC_ELEM_NUM_LSB +: `TFC_ELEM_NUM_W] = elem_num;
      img[`TFC_CTX_EN_BIT]                      = ctx_en;
      img[`TFC_CTX_NUM_LSB +: `TFC_CTX_NUM_W]   = ctx_num;
      img[`TFC_MODE_LSB +: `TFC_MODE_W]         = mode;
      img[`TFC_SUBSET_LSB +: `TFC_SUBSET_W]     = subset;
      img[`TFC_BUF_IMPL_BIT]                    = buf_impl;
      img[`TFC_BUF_USE_BIT]                     = buf_use;
      img[`TFC_SYNC_LSB +: `TFC_SYNC_W]         = sync;
      return img;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////////

   logic [1:0]  sync_period_extension;
   logic        element_filter_enable;
   logic [7:0]  element_number;
   logic        context_filter_enable;
   logic [7:0]  context_number;
   tfc_mode_t   content_select;
   logic        buffers_implemented;
   logic        buffer_in_use;
   logic [2:0]  sync_period;
   logic        loaded;

   logic [1:0]  next_sync_period_extension;
   logic        next_element_filter_enable;
   logic [7:0]  next_element_number;
   logic        next_context_filter_enable;
   logic [7:0]  next_context_number;
   tfc_mode_t   next_content_select;
   logic        next_buffers_implemented;
   logic        next_buffer_in_use;
   logic [2:0]  next_sync_period;
   logic        next_loaded;
   logic [31:0] next_reg_rdata;

   logic [31:0] image;
   logic [31:0] merged;
   logic        wr_hit;
   logic        rd_hit;

   assign wr_hit = IMPL & reg_sel & reg_wr; // see [RL1]
   assign rd_hit = reg_sel & reg_rd;

   always_comb
   begin
      image = pack_image(sync_period_extension, element_filter_enable, element_number,
                         context_filter_enable, context_number, content_select,
                         `TFC_SUBSET_PRESET, buffers_implemented, buffer_in_use, sync_period);
      merged = (reg_wdata & `TFC_WRITE_MASK) | (image & ~`TFC_WRITE_MASK); // see [RL12]
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      next_sync_period_extension = sync_period_extension;
      next_element_filter_enable = element_filter_enable;
      next_element_number        = element_number;
      next_context_filter_enable = context_filter_enable;
      next_context_number        = context_number;
      next_content_select        = content_select;
      if (wr_hit)
      begin
         next_sync_period_extension = merged[`TFC_SYNC_EXT_LSB +: `TFC_SYNC_EXT_W];
         next_element_filter_enable = merged[`TFC_ELEM_EN_BIT];
         next_element_number        = merged[`TFC_ELEM_NUM_LSB +: `TFC_ELEM_NUM_W]; // see [RL5]
         next_context_filter_enable = merged[`TFC_CTX_EN_BIT];
         next_context_number        = merged[`TFC_CTX_NUM_LSB +: `TFC_CTX_NUM_W]; // see [RL7]
         next_content_select        = merged[`TFC_MODE_LSB +: `TFC_MODE_W]; // see [RL8]
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sync_period_extension <= `TFC_RST_SYNC_EXT;
         element_filter_enable <= `TFC_RST_ELEM_EN;
         element_number        <= `TFC_RST_ELEM_NUM; // see [RL5]
         context_filter_enable <= `TFC_RST_CTX_EN;
         context_number        <= `TFC_RST_CTX_NUM; // see [RL7]
         content_select        <= `TFC_RST_MODE;
      end
      else
      begin
         sync_period_extension <= next_sync_period_extension;
         element_filter_enable <= next_element_filter_enable;
         element_number        <= next_element_number;
         context_filter_enable <= next_context_filter_enable;
         context_number        <= next_context_number;
         content_select        <= next_content_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////

   // Mirrored fields follow the trace control block only when it loads them.
   always_comb
   begin
      next_buffers_implemented = buffers_implemented;
      next_buffer_in_use       = buffer_in_use;
      next_sync_period         = sync_period;
      next_loaded              = loaded;
      if (IMPL && tcb_load)
      begin
         next_buffers_implemented = tcb_buffers_implemented; // see [RL2]
         next_buffer_in_use       = tcb_buffer_in_use;
         next_sync_period         = tcb_sync_period;
         next_loaded              = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         buffers_implemented <= 1'b0;
         buffer_in_use       <= 1'b0;
         sync_period         <= 3'h0;
         loaded              <= 1'b0;
      end
      else
      begin
         buffers_implemented <= next_buffers_implemented;
         buffer_in_use       <= next_buffer_in_use;
         sync_period         <= next_sync_period;
         loaded              <= next_loaded;
      end
   end

   assign mirror_valid = loaded; // see [RL2]

   ////////////////////////////////////////////////////////////////////////////////////////////////////

   // Read data is captured on a read and held until the next one.
   always_comb
   begin
      next_reg_rdata = reg_rdata;
      if (rd_hit)
      begin
         if (IMPL)
         begin
            next_reg_rdata = image; // see [RL10]
         end
         else
         begin
            next_reg_rdata = `TFC_RST_RDATA; // see [RL1]
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         reg_rdata <= `TFC_RST_RDATA;
      end
      else
      begin
         reg_rdata <= next_reg_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////

   tfc_filter_if fif ();

   assign fif.trace_enabled      = IMPL & trace_on; // see [RL11]
   assign fif.elem_filter_enable = element_filter_enable;
   assign fif.element_number     = element_number;
   assign fif.ctx_filter_enable  = context_filter_enable;
   assign fif.context_number     = context_number;
   assign fif.content_select     = content_select;
   assign fif.supported_subset   = tfc_subset_t'(`TFC_SUBSET_PRESET); // see [RL10]
   assign fif.instr_valid        = instr_valid;
   assign fif.instr_element      = instr_element;
   assign fif.instr_context      = instr_context;

   tfc_filter u_filter
   (
      .clk  (clk),
      .srst (srst),
      .f    (fif.filt_side)
   );

   assign instr_traced    = fif.traced;
   assign emit_pc         = fif.emit[`TFC_MODE_PC];
   assign emit_load_addr  = fif.emit[`TFC_MODE_LD_ADDR];
   assign emit_store_addr = fif.emit[`TFC_MODE_ST_ADDR];
   assign emit_load_data  = fif.emit[`TFC_MODE_LD_DATA];
   assign emit_store_data = fif.emit[`TFC_MODE_ST_DATA];

endmodule // tfc_reg

// file: tfc_params.svh
// Offsets, field positions, reset values and build options of the trace filter control register.
`ifndef TFC_PARAMS_SVH
`define TFC_PARAMS_SVH

`define TFC_TRACE_PRESENT     1'b1
`define TFC_DATA_W            32
`define TFC_SYNC_EXT_LSB      30
`define TFC_SYNC_EXT_W        2
`define TFC_ELEM_EN_BIT       29
`define TFC_ELEM_NUM_LSB      21
`define TFC_ELEM_NUM_W        8
`define TFC_CTX_EN_BIT        20
`define TFC_CTX_NUM_LSB       12
`define TFC_CTX_NUM_W         8
`define TFC_MODE_LSB          7
`define TFC_MODE_W            5
`define TFC_SUBSET_LSB        5
`define TFC_SUBSET_W          2
`define TFC_BUF_IMPL_BIT      4
`define TFC_BUF_USE_BIT       3
`define TFC_SYNC_LSB          0
`define TFC_SYNC_W            3
`define TFC_MODE_PC           0
`define TFC_MODE_LD_ADDR      1
`define TFC_MODE_ST_ADDR      2
`define TFC_MODE_LD_DATA      3
`define TFC_MODE_ST_DATA      4
`define TFC_MODE_COUNT        5
`define TFC_CTX_CMP_W         3
`define TFC_SUBSET_PRESET     2'h2
`define TFC_RST_SYNC_EXT      2'h0
`define TFC_RST_ELEM_EN       1'b0
`define TFC_RST_ELEM_NUM      8'h00
`define TFC_RST_CTX_EN        1'b0
`define TFC_RST_CTX_NUM       8'h00
`define TFC_RST_MODE          5'h00
`define TFC_RST_RDATA         32'h00000000
`define TFC_WRITE_MASK        32'hFFFFFF80

`endif

// file: tfc_pkg.sv
// Types shared by the trace filter control register and its filter.
package tfc_pkg;

   typedef logic [4:0] tfc_mode_t;

   typedef enum logic [1:0]
   {
      TFC_SUBSET_PC_ONLY,
      TFC_SUBSET_PC_ADDR,
      TFC_SUBSET_PC_ADDR_DATA,
      TFC_SUBSET_RESERVED
   } tfc_subset_t;

endpackage

// file: tfc_filter_if.sv
// Configuration and results passed between the register and the trace filter.
`timescale 1ns/1ns
interface tfc_filter_if;
   import tfc_pkg::*;

   logic        trace_enabled;
   logic        elem_filter_enable;
   logic [7:0]  element_number;
   logic        ctx_filter_enable;
   logic [7:0]  context_number;
   tfc_mode_t   content_select;
   tfc_subset_t supported_subset;
   logic        instr_valid;
   logic [7:0]  instr_element;
   logic [7:0]  instr_context;
   logic        traced;
   tfc_mode_t   emit;

   modport reg_side
   (
      output trace_enabled, elem_filter_enable, element_number, ctx_filter_enable,
      output context_number, content_select, supported_subset,
      output instr_valid, instr_element, instr_context,
      input  traced, emit
   );

   modport filt_side
   (
      input  trace_enabled, elem_filter_enable, element_number, ctx_filter_enable,
      input  context_number, content_select, supported_subset,
      input  instr_valid, instr_element, instr_context,
      output traced, emit
   );

endinterface // tfc_filter_if

// file: tfc_filter.sv
// Per-instruction trace qualification by element, context and content select.
`timescale 1ns/1ns
`include "tfc_params.svh"
module tfc_filter
   import tfc_pkg::*;
(
   input wire logic      clk,
   input wire logic      srst,
   tfc_filter_if.filt_side f
);

   // Tells whether the supported subset allows the given content kind.
   function automatic logic subset_allows(input tfc_subset_t s, input int kind);
      logic ok;
      ok = 1'b0;
      case (s)
         TFC_SUBSET_PC_ONLY:      ok = (kind == `TFC_MODE_PC);
         TFC_SUBSET_PC_ADDR:      ok = (kind <= `TFC_MODE_ST_ADDR);
         TFC_SUBSET_PC_ADDR_DATA: ok = 1'b1;
         default:                 ok = 1'b0;
      endcase
      return ok;
   endfunction

   logic      match;
   logic      next_traced;
   tfc_mode_t next_emit;
   logic      traced;
   tfc_mode_t emit;

   always_comb
   begin
      if (f.ctx_filter_enable)
      begin
         match = (f.instr_context[`TFC_CTX_CMP_W-1:0] == f.context_number[`TFC_CTX_CMP_W-1:0]); // see [RL6] see [RL7] see [RL4]
      end
      else if (f.elem_filter_enable)
      begin
         match = (f.instr_element == f.element_number); // see [RL3]
      end
      else
      begin
         match = 1'b1;
      end
      next_traced = f.trace_enabled & f.instr_valid & match; // see [RL11]
   end

   genvar i;
   generate
      for (i = 0; i < `TFC_MODE_COUNT; i++)
      begin : g_emit
         always_comb
         begin
            next_emit[i] = next_traced & f.content_select[i] & subset_allows(f.supported_subset, i); // see [RL8] see [RL9]
         end
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         traced <= 1'b0;
         emit   <= 5'h00;
      end
      else
      begin
         traced <= next_traced;
         emit   <= next_emit;
      end
   end

   assign f.traced = traced;
   assign f.emit   = emit;

endmodule // tfc_filter

// file: tfc_reg_chk.sv
// Port-level assertion checker for the trace filter control register.
`timescale 1ns/1ns
module tfc_reg_chk
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        reg_sel,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        tcb_load,
   input wire logic        tcb_buffers_implemented,
   input wire logic        tcb_buffer_in_use,
   input wire logic [2:0]  tcb_sync_period,
   input wire logic        mirror_valid,
   input wire logic        trace_on,
   input wire logic        instr_valid,
   input wire logic [7:0]  instr_element,
   input wire logic [7:0]  instr_context,
   input wire logic        instr_traced,
   input wire logic        emit_pc,
   input wire logic        emit_load_addr,
   input wire logic        emit_store_addr,
   input wire logic        emit_load_data,
   input wire logic        emit_store_data
);
   logic [24:0] w_img;
   logic [24:0] next_w_img;
   logic [4:0]  m_img;
   logic [4:0]  next_m_img;
   logic [4:0]  mode;
   logic [4:0]  emits;
   logic        cand;
   logic        elem_hit;
   logic        ctx_hit;
   ////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_w_img = (reg_sel && reg_wr) ? reg_wdata[31:7] : w_img;
      next_m_img = tcb_load ? {tcb_buffers_implemented, tcb_buffer_in_use, tcb_sync_period} : m_img;
      if (srst)
      begin
         next_w_img = 25'h0000000;
         next_m_img = 5'h00;
      end
      mode = w_img[4:0];
      emits = {emit_store_data, emit_load_data, emit_store_addr, emit_load_addr, emit_pc};
      cand = instr_valid && trace_on;
      elem_hit = !w_img[22] || (instr_element == w_img[21:14]);
      ctx_hit = instr_context[2:0] == w_img[7:5];
   end
   always_ff @(posedge clk)
   begin
      w_img <= next_w_img;
      m_img <= next_m_img;
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_reset_clear: assert property (disable iff (1'b0) srst |=> reg_rdata == 32'h00000000 && !mirror_valid && !instr_traced)
      else $error("outputs not cleared by reset");
   a_elem_filter: assert property (cand && !w_img[13] |=> instr_traced == $past(elem_hit))
      else $error("element filter result wrong");
   a_ctx_filter: assert property (cand && w_img[13] |=> instr_traced == $past(ctx_hit))
      else $error("context filter result wrong");
   a_trace_quiet: assert property (!cand |=> !instr_traced && emits == 5'h00)
      else $error("trace output while trace is off");
   a_emit_select: assert property (instr_traced |-> emits == $past(mode))
      else $error("content enables not followed");
   a_emit_gated: assert property (!instr_traced |-> emits == 5'h00)
      else $error("content emitted without trace");
   a_rw_readback: assert property (reg_sel && reg_rd |=> reg_rdata[31:5] == {$past(w_img), 2'h2})
      else $error("read-write image wrong");
   a_mirror_read: assert property (reg_sel && reg_rd |=> reg_rdata[4:0] == $past(m_img))
      else $error("mirrored fields wrong");
   a_mirror_valid: assert property (tcb_load |=> mirror_valid)
      else $error("mirror valid not set after load");
   a_rdata_hold: assert property (!(reg_sel && reg_rd) |=> $stable(reg_rdata))
      else $error("read data changed without read");
   c_load: cover property (tcb_load ##1 reg_sel && reg_rd);
   c_ctx: cover property (cand && w_img[13] && w_img[22]);
   c_emit: cover property (instr_traced && emit_store_data);
endmodule // tfc_reg_chk

bind tfc_reg tfc_reg_chk chk (.clk(clk), .srst(srst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tcb_load(tcb_load),
   .tcb_buffers_implemented(tcb_buffers_implemented), .tcb_buffer_in_use(tcb_buffer_in_use),
   .tcb_sync_period(tcb_sync_period), .mirror_valid(mirror_valid),
   .trace_on(trace_on), .instr_valid(instr_valid), .instr_element(instr_element), .instr_context(instr_context),
   .instr_traced(instr_traced), .emit_pc(emit_pc), .emit_load_addr(emit_load_addr),
   .emit_store_addr(emit_store_addr), .emit_load_data(emit_load_data), .emit_store_data(emit_store_data));

// file: tfc_tcb_model.sv
// Trace control block stand-in that loads the mirrored fields.
`timescale 1ns/1ns
module tfc_tcb_model
(
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       req,
   input wire logic [4:0] req_val,
   output logic           tcb_load = 1'b0,
   output logic [4:0]     tcb_val = 5'h13
);
   logic [4:0] junk = 5'h0A;
   // Values are only meaningful with the load strobe; otherwise they churn.
   always @(posedge clk)
   begin
      junk <= junk + 5'h0B;
      tcb_load <= req && !srst;
      tcb_val <= req ? req_val : junk;
   end
endmodule // tfc_tcb_model

// file: trace_filter_control_register_tb_top.sv
// Self-checking testbench for the trace filter control register.
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) \
   begin fails++; $display("FAIL %0t mismatch %h %h", $time, g, e); end end
module trace_filter_control_register_tb_top;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        reg_sel = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        trace_on = 1'b0;
   logic        instr_valid = 1'b0;
   logic        req = 1'b0;
   logic [31:0] reg_wdata = 32'h00000000;
   logic [7:0]  instr_element = 8'h00;
   logic [7:0]  instr_context = 8'h00;
   logic [4:0]  req_val = 5'h00;
   logic [31:0] reg_rdata;
   logic        mirror_valid;
   logic        instr_traced;
   logic [4:0]  emits;
   logic        tcb_load;
   logic [4:0]  tcb_val;
   int          fails = 0;
   int          total_checks = 0;
   always #20 clk = ~clk;
   tfc_tcb_model tcb (.clk(clk), .srst(srst), .req(req), .req_val(req_val), .tcb_load(tcb_load), .tcb_val(tcb_val));
   tfc_reg uut (.clk(clk), .srst(srst), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .tcb_load(tcb_load), .tcb_buffers_implemented(tcb_val[4]),
      .tcb_buffer_in_use(tcb_val[3]), .tcb_sync_period(tcb_val[2:0]), .mirror_valid(mirror_valid),
      .trace_on(trace_on), .instr_valid(instr_valid), .instr_element(instr_element), .instr_context(instr_context),
      .instr_traced(instr_traced), .emit_pc(emits[0]), .emit_load_addr(emits[1]), .emit_store_addr(emits[2]),
      .emit_load_data(emits[3]), .emit_store_data(emits[4]));
   ////////////////////////////////////////////////////////////////////////////////
   task wr(input logic [31:0] d);
      @(posedge clk);
      reg_sel <= 1'b1;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge clk);
      reg_sel <= 1'b0;
      reg_wr <= 1'b0;
   endtask
   task rd_chk(input logic [31:0] e);
      @(posedge clk);
      reg_sel <= 1'b1;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_sel <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   task ins(input logic [7:0] el, input logic [7:0] cx, input logic [4:0] e, input logic t);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_element <= el;
      instr_context <= cx;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      `CHK(instr_traced, t)
      `CHK(emits, e)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_regs;
      rd_chk(32'h00000040);
      `CHK(mirror_valid, 1'b0)
      wr(32'hFFFFFFFF);
      rd_chk(32'hFFFFFFC0);
      @(posedge clk);
      req <= 1'b1;
      req_val <= 5'h15;
      @(posedge clk);
      req <= 1'b0;
      rd_chk(32'hFFFFFFD5);
      `CHK(mirror_valid, 1'b1)
      wr(32'h00000000);
      rd_chk(32'h00000055);
      $display("test regs done");
   endtask
   task t_filter;
      @(posedge clk);
      trace_on <= 1'b1;
      wr(32'h00000F80);
      ins(8'h77, 8'h66, 5'h1F, 1'b1);
      wr(32'h2B400F80);
      ins(8'h5A, 8'h00, 5'h1F, 1'b1);
      ins(8'h5B, 8'h00, 5'h00, 1'b0);
      ins(8'hDA, 8'h00, 5'h00, 1'b0);
      wr(32'h2B50BF80);
      ins(8'h00, 8'h13, 5'h1F, 1'b1);
      ins(8'h5A, 8'h0C, 5'h00, 1'b0);
      $display("test filter done");
   endtask
   task t_modes;
      for (int i = 0; i < 5; i++)
      begin
         wr(32'h00000080 << i);
         ins(8'h01, 8'h01, 5'h01 << i, 1'b1);
      end
      wr(32'h00000000);
      ins(8'h01, 8'h01, 5'h00, 1'b1);
      wr(32'h00000F80);
      @(posedge clk);
      trace_on <= 1'b0;
      ins(8'h01, 8'h01, 5'h00, 1'b0);
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      rd_chk(32'h00000040);
      `CHK(mirror_valid, 1'b0)
      $display("test modes done");
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_filter();
      t_modes();
      wrap_up();
   end
   initial
   begin
      #400000;
      fails++;
      wrap_up();
   end
endmodule // trace_filter_control_register_tb_top
